// File: src/pswc_top.sv
// Purpose: power state sequencer with switch timing and wake sources
// Assumes: wake inputs and the switch are asynchronous levels, active high except pcie_wake_n, which is active low
// Notes: network wake detection is reported by the network block on net_wake
//
// Functional notes
// - short press in soft-off or sleep moves system to working.
// - short press while working requests sleep or soft-off per os setting.
// - hold over six seconds while working or sleeping forces soft-off.
// - after mains return enter on, off or previous state per policy.
// - in suspend-to-ram indicator is amber if dual colour else off.
// - wake from suspend-to-ram returns to working state.
// - network block watches traffic during sleep for wake frames.
// - recognised network wake frame powers the system up.
// - usb activity wakes from s3, s4 and s5.
// - usb wake from s4 and s5 gated by firmware option.
// - pcie wake signal wakes from s3, s4 or s5.
// - rtc alarm match wakes from s5 when alarm is armed.
// - infrared activity wakes from s3, s4 or s5.
// - rtc, network and pcie wakes keep the monitor asleep.
// - usb and infrared wake from s4/s5 only with deep standby off.
// - network wake from s5 after mains loss only with deep standby off.
// - usb and infrared wake ignored right after mains return.
// - no wake on bluetooth events.
// - power switch wakes from s3, s4 and s5.
`timescale 1ns/1ps
`default_nettype none
module pswc_top
    import pswc_pkg::*;
#(
    parameter longint unsigned SHORT_CYC = SHORT_PRESS_CYC,
    parameter longint unsigned FORCE_CYC = FORCE_OFF_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire pswc_cfg_s cfg,
    input wire logic last_state_on,
    input wire logic power_switch,
    input wire logic rtc_alarm,
    input wire logic rtc_armed,
    input wire logic net_wake,
    input wire logic usb_wake,
    input wire logic pcie_wake_n,
    input wire logic infrared_remote_wake,
    input wire logic bluetooth_wake,
    input wire logic os_sleep_req,
    output logic main_power_en,
    output logic sleep_req,
    output logic net_monitor_en,
    output logic monitor_wake,
    output var pswc_led_e led,
    output var pswc_state_e state
);
    // =========================================================
    // reset release and input synchronisers
    logic rst_meta_reg, rst_n_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    logic [7:0] raw_in, sync_in;
    assign raw_in = {os_sleep_req, ~pcie_wake_n, infrared_remote_wake, usb_wake,
                     net_wake, rtc_alarm, power_switch, rtc_armed};
    for (genvar i = 0; i < 8; i++) begin : g_sync
        pswc_sync u_sync (
            .clock(clock),
            .rst_n(rst_n_reg),
            .d(raw_in[i]),
            .q(sync_in[i])
        );
    end
    logic armed_s, sw_s, rtc_s, net_s, usb_s, ir_s, pcie_s, os_s;
    assign {os_s, pcie_s, ir_s, usb_s, net_s, rtc_s, sw_s, armed_s} = sync_in;

    // bluetooth is synchronised nowhere and feeds no logic; only an assertion watches it
    logic unused_bt;
    assign unused_bt = bluetooth_wake;

    // =========================================================
    // switch timing
    logic short_rel, force_off;
    pswc_press_timer #(
        .SHORT_CYC(SHORT_CYC),
        .FORCE_CYC(FORCE_CYC)
    ) u_press (
        .clock(clock),
        .rst_n(rst_n_reg),
        .pressed(sw_s),
        .short_release(short_rel),
        .force_off(force_off)
    );

    // =========================================================
    // wake qualification
    logic sleeping, in_s45;
    logic post_loss_reg, post_loss_next;
    logic g3_s5_reg, g3_s5_next;
    logic [WK_N-1:0] wake;
    logic any_wake;
    logic state_valid_reg, state_valid_next;
    pswc_state_e state_reg, state_next;
    logic [1:0] pol;

    assign sleeping = (state_reg != PSWC_S0);
    assign in_s45 = (state_reg == PSWC_S4) || (state_reg == PSWC_S5);

    always_comb begin
        wake = '0;
        wake[WK_SWITCH] = short_rel;
        wake[WK_RTC] = rtc_s && armed_s && (state_reg == PSWC_S5);
        // network wake after a mains-loss entry into s5 needs deep standby off
        wake[WK_NET] = net_s && !(g3_s5_reg && cfg.deep_standby_en);
        wake[WK_PCIE] = pcie_s;
        wake[WK_USB] = usb_s && !post_loss_reg
            && (!in_s45 || (cfg.usb_wake_s45_en && !cfg.deep_standby_en));
        wake[WK_IR] = ir_s && !post_loss_reg
            && (!in_s45 || !cfg.deep_standby_en);
        any_wake = sleeping && (|wake);
    end

    // =========================================================
    // state sequencing
    logic mon_reg, mon_next;
    logic sleep_req_reg, sleep_req_next;

    assign pol = cfg.restore_policy;

    always_comb begin
        state_next = state_reg;
        state_valid_next = 1'b1;
        post_loss_next = post_loss_reg;
        g3_s5_next = g3_s5_reg;
        mon_next = mon_reg;
        sleep_req_next = 1'b0;
        if (!state_valid_reg) begin
            // first cycle after mains return applies the restore policy
            if (pol == RESTORE_ON || (pol == RESTORE_LAST && last_state_on)) begin
                state_next = PSWC_S0;
                mon_next = 1'b1;
            end else begin
                state_next = PSWC_S5;
                g3_s5_next = 1'b1;
            end
        end else if (force_off && sleeping) begin
            state_next = PSWC_S5;
            post_loss_next = 1'b0;
        end else if (force_off) begin
            state_next = PSWC_S5;
            mon_next = 1'b0;
            post_loss_next = 1'b0;
        end else if (any_wake) begin
            state_next = PSWC_S0;
            post_loss_next = 1'b0;
            g3_s5_next = 1'b0;
            // monitor stays asleep unless a user-facing source took part
            mon_next = wake[WK_SWITCH] || wake[WK_USB] || wake[WK_IR];
        end else if (state_reg == PSWC_S0 && (short_rel || os_s)) begin
            sleep_req_next = 1'b1;
            post_loss_next = 1'b0;
            mon_next = 1'b0;
            if (cfg.sleep_to_s5) begin
                state_next = PSWC_S5;
            end else if (cfg.sleep_to_s4) begin
                state_next = PSWC_S4;
            end else begin
                state_next = PSWC_S3;
            end
        end
        // a mid-band release produces short_rel=0 and force_off=0: no change
    end

    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= PSWC_S5;
            state_valid_reg <= 1'b0;
            post_loss_reg <= 1'b1;
            g3_s5_reg <= 1'b0;
            mon_reg <= 1'b0;
            sleep_req_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            state_valid_reg <= state_valid_next;
            post_loss_reg <= post_loss_next;
            g3_s5_reg <= g3_s5_next;
            mon_reg <= mon_next;
            sleep_req_reg <= sleep_req_next;
        end
    end

    // =========================================================
    // outputs
    pswc_led_e led_reg, led_next;
    always_comb begin
        unique case (state_next)
            PSWC_S0: led_next = PSWC_LED_GREEN;
            PSWC_S3: led_next = cfg.dual_colour_led ? PSWC_LED_AMBER : PSWC_LED_OFF;
            default: led_next = PSWC_LED_OFF;
        endcase
    end
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            led_reg <= PSWC_LED_OFF;
        end else begin
            led_reg <= led_next;
        end
    end

    assign main_power_en = (state_reg == PSWC_S0);
    assign net_monitor_en = sleeping;
    assign monitor_wake = mon_reg;
    assign sleep_req = sleep_req_reg;
    assign led = led_reg;
    assign state = state_reg;

    // =========================================================
    // assertions
    property p_short_wakes;
        @(posedge clock) disable iff (!rst_n_reg)
        (state_valid_reg && short_rel && sleeping && !force_off) |=> (state_reg == PSWC_S0);
    endproperty
    a_short_wakes: assert property (p_short_wakes) else $error("short press did not wake");


    property p_short_sleeps;
        @(posedge clock) disable iff (!rst_n_reg)
        (state_valid_reg && short_rel && !sleeping && !force_off) |=> sleep_req && sleeping;
    endproperty
    a_short_sleeps: assert property (p_short_sleeps) else $error("short press did not sleep");


    property p_force;
        @(posedge clock) disable iff (!rst_n_reg)
        (state_valid_reg && force_off) |=> (state_reg == PSWC_S5);
    endproperty
    a_force: assert property (p_force) else $error("force off missed");


    property p_restore;
        @(posedge clock) disable iff (!rst_n_reg)
        (!state_valid_reg && pol == RESTORE_ON) |=> main_power_en;
    endproperty
    a_restore: assert property (p_restore) else $error("restore on failed");


    property p_amber;
        @(posedge clock) disable iff (!rst_n_reg)
        ($past(state_next) == PSWC_S3 && $past(cfg.dual_colour_led)) |-> led == PSWC_LED_AMBER;
    endproperty
    a_amber: assert property (p_amber) else $error("s3 indicator not amber");


    property p_mon_sleep;
        @(posedge clock) disable iff (!rst_n_reg)
        (any_wake && !force_off && state_valid_reg && !wake[WK_SWITCH] && !wake[WK_USB]
            && !wake[WK_IR]) |=> !monitor_wake;
    endproperty
    a_mon_sleep: assert property (p_mon_sleep) else $error("monitor woke");


    property p_post_loss;
        @(posedge clock) disable iff (!rst_n_reg)
        (state_valid_reg && post_loss_reg && sleeping && (usb_s || ir_s) && !short_rel
            && !force_off && !rtc_s && !net_s && !pcie_s) |=> $stable(state_reg);
    endproperty
    a_post_loss: assert property (p_post_loss) else $error("usb or ir wake after loss");

    property p_deep;
        @(posedge clock) disable iff (!rst_n_reg)
        (state_valid_reg && in_s45 && cfg.deep_standby_en && (usb_s || ir_s) && !short_rel
            && !force_off && !rtc_s && !net_s && !pcie_s) |=> $stable(state_reg);
    endproperty
    a_deep: assert property (p_deep) else $error("deep standby wake");


    property p_pcie;
        @(posedge clock) disable iff (!rst_n_reg)
        (state_valid_reg && sleeping && pcie_s && !force_off) |=> main_power_en;
    endproperty
    a_pcie: assert property (p_pcie) else $error("pcie wake missed");

    property p_rtc;
        @(posedge clock) disable iff (!rst_n_reg)
        (state_valid_reg && state_reg == PSWC_S5 && rtc_s && armed_s && !force_off)
            |=> main_power_en;
    endproperty
    a_rtc: assert property (p_rtc) else $error("rtc alarm wake missed");

    property p_sleep_pulse;
        @(posedge clock) disable iff (!rst_n_reg)
        sleep_req |=> !sleep_req;
    endproperty
    a_sleep_pulse: assert property (p_sleep_pulse) else $error("sleep request held");

    property p_usb_gate;
        @(posedge clock) disable iff (!rst_n_reg)
        (state_valid_reg && in_s45 && !cfg.usb_wake_s45_en && usb_s && !ir_s && !short_rel
            && !force_off && !rtc_s && !net_s && !pcie_s) |=> $stable(state_reg);
    endproperty
    a_usb_gate: assert property (p_usb_gate) else $error("usb wake while disabled");

    property p_bt;
        @(posedge clock) disable iff (!rst_n_reg)
        (state_valid_reg && sleeping && bluetooth_wake && !short_rel && !force_off && !rtc_s
            && !net_s && !pcie_s && !usb_s && !ir_s)
            |=> $stable(state_reg);
    endproperty
    a_bt: assert property (p_bt) else $error("bluetooth woke the system");
endmodule : pswc_top
`default_nettype wire

// File: src/pswc_pkg.sv
// Purpose: shared constants and types for the power state and wake controller
// Assumes: 125 MHz clock
// Notes: press times are long counts; the top exposes them as parameters
package pswc_pkg;
    // =========================================================
    // timing
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned SHORT_PRESS_S = 4;
    localparam int unsigned FORCE_OFF_S = 6;
    localparam longint unsigned SHORT_PRESS_CYC = longint'(SHORT_PRESS_S) * CLK_HZ;
    localparam longint unsigned FORCE_OFF_CYC = longint'(FORCE_OFF_S) * CLK_HZ;
    localparam int CNT_W = 30;

    // =========================================================
    // restore policy codes
    localparam logic [1:0] RESTORE_OFF = 2'h0;
    localparam logic [1:0] RESTORE_ON = 2'h1;
    localparam logic [1:0] RESTORE_LAST = 2'h2;

    // =========================================================
    // wake source indices
    localparam int WK_SWITCH = 0;
    localparam int WK_RTC = 1;
    localparam int WK_NET = 2;
    localparam int WK_USB = 3;
    localparam int WK_PCIE = 4;
    localparam int WK_IR = 5;
    localparam int WK_N = 6;

    typedef enum logic [3:0] {
        PSWC_S0 = 4'h1,
        PSWC_S3 = 4'h2,
        PSWC_S4 = 4'h4,
        PSWC_S5 = 4'h8
    } pswc_state_e;

    typedef enum logic [1:0] {
        PSWC_LED_OFF = 2'h0,
        PSWC_LED_GREEN = 2'h1,
        PSWC_LED_AMBER = 2'h2
    } pswc_led_e;

    typedef struct packed {
        logic deep_standby_en;
        logic usb_wake_s45_en;
        logic [1:0] restore_policy;
        logic dual_colour_led;
        logic sleep_to_s4;
        logic sleep_to_s5;
    } pswc_cfg_s;
endpackage : pswc_pkg

// File: src/pswc_sync.sv
// Purpose: two flip-flop synchroniser for one level
// Assumes: async input
// Notes: first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module pswc_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_reg;
    logic q_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            q_reg <= 1'b0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end
    assign q = q_reg;
endmodule : pswc_sync
`default_nettype wire

// File: src/pswc_press_timer.sv
// Purpose: measures power switch press length, classifies on release
// Assumes: synchronised, debounced level input
// Notes: force pulse fires while still held, once per press
`timescale 1ns/1ps
`default_nettype none
module pswc_press_timer
    import pswc_pkg::*;
#(
    parameter longint unsigned SHORT_CYC = SHORT_PRESS_CYC,
    parameter longint unsigned FORCE_CYC = FORCE_OFF_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pressed,
    output logic short_release,
    output logic force_off
);
    localparam logic [CNT_W-1:0] SHORT_LIM = CNT_W'(SHORT_CYC);
    localparam logic [CNT_W-1:0] FORCE_LIM = CNT_W'(FORCE_CYC);

    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic prev_reg, prev_next;
    logic fired_reg, fired_next;
    logic short_reg, short_next;
    logic force_reg, force_next;

    always_comb begin
        cnt_next = cnt_reg;
        prev_next = pressed;
        fired_next = fired_reg;
        short_next = 1'b0;
        force_next = 1'b0;
        if (pressed) begin
            if (cnt_reg != {CNT_W{1'b1}}) begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
            // strictly longer than the limit
            if (cnt_reg >= FORCE_LIM && !fired_reg) begin
                force_next = 1'b1;
                fired_next = 1'b1;
            end
        end else begin
            // middle band between the two limits does nothing
            if (prev_reg && cnt_reg < SHORT_LIM) begin
                short_next = 1'b1;
            end
            cnt_next = '0;
            fired_next = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            prev_reg <= 1'b0;
            fired_reg <= 1'b0;
            short_reg <= 1'b0;
            force_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            prev_reg <= prev_next;
            fired_reg <= fired_next;
            short_reg <= short_next;
            force_reg <= force_next;
        end
    end

    assign short_release = short_reg;
    assign force_off = force_reg;
endmodule : pswc_press_timer
`default_nettype wire

// File: sim/pswc_wake_model.sv
// Purpose: far-side model of the power switch and the wake event sources
// Assumes: called from the bench; lines move 1 ns after a rising clock edge
// Notes: the pcie wake line is open-drain with a pull-up, so it idles high
`timescale 1ns/1ps
`default_nettype none
module pswc_wake_model
    import pswc_pkg::*;
(
    input wire logic clock,
    output var logic power_switch,
    output var logic rtc_alarm,
    output var logic net_wake,
    output var logic usb_wake,
    output var logic pcie_wake_n,
    output var logic infrared_remote_wake,
    output var logic bluetooth_wake
);
    // ====
    // idle levels
    initial begin
        power_switch = 1'b0;
        rtc_alarm = 1'b0;
        net_wake = 1'b0;
        usb_wake = 1'b0;
        pcie_wake_n = 1'b1;
        infrared_remote_wake = 1'b0;
        bluetooth_wake = 1'b0;
    end

    // ====
    // source lines; index WK_N is the radio link, which must never wake
    function automatic void drive(input int src, input logic on);
        case (src)
            WK_RTC: rtc_alarm = on;
            WK_NET: net_wake = on;
            WK_USB: usb_wake = on;
            WK_PCIE: pcie_wake_n = ~on;
            WK_IR: infrared_remote_wake = on;
            default: bluetooth_wake = on;
        endcase
    endfunction : drive

    // ====
    // events held n cycles, so quick and slow sources can both be played
    task automatic press(input int n);
        @(posedge clock);
        #1 power_switch = 1'b1;
        repeat (n) @(posedge clock);
        #1 power_switch = 1'b0;
    endtask : press

    task automatic raise(input int src, input int n);
        @(posedge clock);
        #1 drive(src, 1'b1);
        repeat (n) @(posedge clock);
        #1 drive(src, 1'b0);
    endtask : raise
endmodule : pswc_wake_model
`default_nettype wire

// File: sim/pswc_top_tb.sv
// Purpose: self-checking bench for the power state and wake controller
// Assumes: press limits shortened to 20 and 30 cycles
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module pswc_top_tb
    import pswc_pkg::*;
;
    localparam longint unsigned SHORT_T = 20;
    localparam longint unsigned FORCE_T = 30;
    localparam int P_SHORT = int'(SHORT_T / 2);
    localparam int P_MID = int'((SHORT_T + FORCE_T) / 2);
    localparam int P_LONG = int'(FORCE_T + 5);

    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic last_state_on = 1'b0;
    logic rtc_armed = 1'b0;
    logic os_sleep_req = 1'b0;
    pswc_cfg_s cfg;
    logic power_switch, rtc_alarm, net_wake, usb_wake, pcie_wake_n, ir_wake, bt_wake;
    logic main_power_en, sleep_req, net_monitor_en, monitor_wake;
    pswc_led_e led;
    pswc_state_e state;
    int err_total = 0;
    int num_checks = 0;
    int sleep_cnt = 0;

    // ====
    // clock and sleep pulse counter
    always #4 clock = ~clock;
    always @(posedge clock) begin
        if (sleep_req === 1'b1) sleep_cnt <= sleep_cnt + 1;
    end

    pswc_top #(.SHORT_CYC(SHORT_T), .FORCE_CYC(FORCE_T)) pswc_top_inst (
        .clock(clock), .resetn(resetn), .cfg(cfg), .last_state_on(last_state_on),
        .power_switch(power_switch), .rtc_alarm(rtc_alarm), .rtc_armed(rtc_armed),
        .net_wake(net_wake), .usb_wake(usb_wake), .pcie_wake_n(pcie_wake_n),
        .infrared_remote_wake(ir_wake), .bluetooth_wake(bt_wake),
        .os_sleep_req(os_sleep_req), .main_power_en(main_power_en), .sleep_req(sleep_req),
        .net_monitor_en(net_monitor_en), .monitor_wake(monitor_wake), .led(led),
        .state(state));

    pswc_wake_model pswc_wake_model_inst (
        .clock(clock), .power_switch(power_switch), .rtc_alarm(rtc_alarm),
        .net_wake(net_wake), .usb_wake(usb_wake), .pcie_wake_n(pcie_wake_n),
        .infrared_remote_wake(ir_wake), .bluetooth_wake(bt_wake));

    // ====
    // helpers
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s is %h not %h", $time, what, seen, exp);
        end
    endtask : chk

    // stay: judge after the answer time has passed; else wait, bounded
    task automatic es(input pswc_state_e exp, input bit stay);
        int i;
        i = 0;
        while (!stay && state !== exp && i < 40) begin
            @(posedge clock);
            #1;
            i++;
        end
        if (stay) begin
            repeat (10) @(posedge clock);
            #1;
        end
        chk(4'(state), 4'(exp), "state");
        if (!stay && state !== exp) stop_test();
    endtask : es

    task automatic prs(input int n);
        pswc_wake_model_inst.press(n);
    endtask : prs

    task automatic wk(input int src);
        pswc_wake_model_inst.raise(src, 4);
    endtask : wk

    task automatic go(input logic to4, input logic to5, input pswc_state_e tgt);
        cfg.sleep_to_s4 = to4;
        cfg.sleep_to_s5 = to5;
        prs(P_SHORT);
        es(tgt, 1'b0);
    endtask : go

    task automatic do_reset(input logic [1:0] pol, input logic last);
        @(posedge clock);
        #1 resetn = 1'b0;
        cfg.restore_policy = pol;
        last_state_on = last;
        repeat (3) @(posedge clock);
        #1 resetn = 1'b1;
    endtask : do_reset

    // ====
    // scenarios
    task automatic t_restore();
        for (int k = 0; k < 4; k++) begin
            do_reset(k == 0 ? RESTORE_OFF : (k == 1 ? RESTORE_ON : RESTORE_LAST), k == 2);
            es((k == 1 || k == 2) ? PSWC_S0 : PSWC_S5, 1'b1);
            chk(4'(main_power_en), 4'(k == 1 || k == 2), "power");
        end
    endtask : t_restore

    task automatic t_post_loss();
        wk(WK_USB);
        es(PSWC_S5, 1'b1);
        wk(WK_IR);
        es(PSWC_S5, 1'b1);
        wk(WK_NET);
        es(PSWC_S0, 1'b0);
        chk(4'(monitor_wake), 4'h0, "monitor");
    endtask : t_post_loss

    task automatic t_deep();
        cfg.deep_standby_en = 1'b1;
        do_reset(RESTORE_OFF, 1'b0);
        wk(WK_NET);
        es(PSWC_S5, 1'b1);
        prs(P_SHORT);
        es(PSWC_S0, 1'b0);
        cfg.deep_standby_en = 1'b0;
    endtask : t_deep

    task automatic t_switch();
        int n;
        n = sleep_cnt;
        go(1'b0, 1'b0, PSWC_S3);
        @(posedge clock);
        #1;
        chk(4'(sleep_cnt - n), 4'h1, "sleep pulses");
        chk(4'(sleep_req), 4'h0, "sleep pulse length");
        chk(4'(led), 4'(PSWC_LED_AMBER), "led");
        chk(4'(main_power_en), 4'h0, "power");
        chk(4'(net_monitor_en), 4'h1, "net monitor");
        prs(P_SHORT);
        es(PSWC_S0, 1'b0);
        chk(4'(monitor_wake), 4'h1, "monitor");
        chk(4'(led), 4'(PSWC_LED_GREEN), "led");
        chk(4'(net_monitor_en), 4'h0, "net monitor");
        prs(P_MID);
        es(PSWC_S0, 1'b1);
        prs(P_LONG);
        es(PSWC_S5, 1'b0);
        prs(P_MID);
        es(PSWC_S5, 1'b1);
        prs(P_SHORT);
        es(PSWC_S0, 1'b0);
        go(1'b1, 1'b0, PSWC_S4);
        prs(P_LONG);
        es(PSWC_S5, 1'b0);
        prs(P_SHORT);
        es(PSWC_S0, 1'b0);
    endtask : t_switch

    task automatic t_wake_table();
        int srcs [4] = '{WK_USB, WK_IR, WK_PCIE, WK_NET};
        pswc_state_e tg [3] = '{PSWC_S3, PSWC_S4, PSWC_S5};
        for (int t = 0; t < 3; t++) begin
            for (int k = 0; k < 4; k++) begin
                go(t == 1, t == 2, tg[t]);
                wk(srcs[k]);
                es(PSWC_S0, 1'b0);
                chk(4'(monitor_wake), 4'(k < 2), "monitor");
            end
        end
        go(1'b0, 1'b1, PSWC_S5);
        wk(WK_RTC);
        es(PSWC_S5, 1'b1);
        rtc_armed = 1'b1;
        wk(WK_RTC);
        es(PSWC_S0, 1'b0);
        chk(4'(monitor_wake), 4'h0, "monitor");
    endtask : t_wake_table

    task automatic t_gating();
        cfg.usb_wake_s45_en = 1'b0;
        go(1'b1, 1'b0, PSWC_S4);
        wk(WK_USB);
        es(PSWC_S4, 1'b1);
        cfg.usb_wake_s45_en = 1'b1;
        cfg.deep_standby_en = 1'b1;
        wk(WK_IR);
        es(PSWC_S4, 1'b1);
        wk(WK_USB);
        es(PSWC_S4, 1'b1);
        wk(WK_N);
        es(PSWC_S4, 1'b1);
        prs(P_SHORT);
        es(PSWC_S0, 1'b0);
        cfg.deep_standby_en = 1'b0;
        cfg.dual_colour_led = 1'b0;
        go(1'b0, 1'b0, PSWC_S3);
        chk(4'(led), 4'(PSWC_LED_OFF), "led");
        wk(WK_N);
        es(PSWC_S3, 1'b1);
        wk(WK_USB);
        es(PSWC_S0, 1'b0);
        os_sleep_req = 1'b1;
        es(PSWC_S3, 1'b0);
        os_sleep_req = 1'b0;
    endtask : t_gating

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        cfg = '0;
        cfg.usb_wake_s45_en = 1'b1;
        cfg.dual_colour_led = 1'b1;
        t_restore();
        t_post_loss();
        t_deep();
        t_switch();
        t_wake_table();
        t_gating();
        stop_test();
    end
endmodule : pswc_top_tb
`default_nettype wire
